// ---- rtl/sdram_cmd_pkg.sv ----
/*
 holds the constants shared by both ends of the command link: widths,
 command strobe codes, mode encodings and the controller's spacing counts.
 assumes a single 125 MHz clock shared by both ends.
*/
package sdram_cmd_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int BANKS      = 4;
   localparam int BANK_W     = 2;
   localparam int ADDR_W     = 12;
   localparam int COL_W      = 8;
   localparam int MASK_W     = 4;
   localparam int DATA_W     = 32;
   localparam int AP_BIT     = 10;
   localparam int BURST_W    = 9;
   // ---------------------------------------------------------------
   // command strobes {row, column, write}, active low
   // ---------------------------------------------------------------
   localparam logic [2:0] CMD_MODE  = 3'h0;
   localparam logic [2:0] CMD_REFR  = 3'h1;
   localparam logic [2:0] CMD_PRE   = 3'h2;
   localparam logic [2:0] CMD_ACT   = 3'h3;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_READ  = 3'h5;
   localparam logic [2:0] CMD_STOP  = 3'h6;
   localparam logic [2:0] CMD_NOP   = 3'h7;
   // ---------------------------------------------------------------
   // full page burst length code and reset values
   // ---------------------------------------------------------------
   localparam logic [BURST_W-1:0] FULL_PAGE   = 9'h000;
   localparam logic [BURST_W-1:0] BURST_RESET = 9'h004;
   // ---------------------------------------------------------------
   // controller spacing, times in ns
   // ---------------------------------------------------------------
   localparam int CLK_NS = 8;
   localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 18;
   localparam int SAME_BANK_ACTIVATE_CYCLE_NS = 60;
   localparam int BANK_TO_BANK_ACTIVATE_GAP_NS = 12;
   localparam int ACTIVE_MIN_NS = 42;
   localparam int ACTIVATE_TO_ACCESS_DELAY_CYC = (ACTIVATE_TO_ACCESS_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int SAME_BANK_ACTIVATE_CYCLE_CYC = (SAME_BANK_ACTIVATE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int BANK_TO_BANK_ACTIVATE_GAP_CYC = (BANK_TO_BANK_ACTIVATE_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACTIVE_MIN_CYC = (ACTIVE_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 4;

   typedef enum logic [1:0] {
      MODE_RUN     = 2'b00,
      MODE_PDOWN   = 2'b01,
      MODE_SUSPEND = 2'b10,
      MODE_SREF    = 2'b11
   } mode_type;

   typedef enum logic [1:0] {
      REQ_ACT   = 2'b00,
      REQ_PRE   = 2'b01,
      REQ_READ  = 2'b10,
      REQ_WRITE = 2'b11
   } req_type;

   function automatic logic [CNT_W-1:0] cnt_of(input int cycles);
      cnt_of = CNT_W'(cycles);
   endfunction
endpackage

// ---- rtl/sdram_cmd_if.sv ----
/*
 holds the command pin bundle between the controller end and the memory end.
 assumes both ends run on the same clock; write data only flows controller to memory.
*/
interface sdram_cmd_if;
   import sdram_cmd_pkg::*;
   logic              cs_n;
   logic              ras_n;
   logic              cas_n;
   logic              we_n;
   logic              cke;
   logic [BANK_W-1:0] bank_select;
   logic [ADDR_W-1:0] addr;
   logic [MASK_W-1:0] byte_mask;
   logic [DATA_W-1:0] wdata;

   modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, bank_select, addr, byte_mask, wdata);
   modport mem  (input  cs_n, ras_n, cas_n, we_n, cke, bank_select, addr, byte_mask, wdata);
endinterface

// ---- rtl/sdram_cmd_decode.sv ----
/*
 holds the memory end: command decode, clock-enable modes and per-bank row state.
 assumes the command pins come from the controller on the same clock edge domain;
 pins still pass two flops since they arrive from outside the chip.
*/
// Function
// - sample command pins on rising clock edge
// - chip select high means deselect, ignore rest
// - decode mode load, nop, burst stop
// - refresh: auto with gate high, self-refresh low
// - commands need prior gate high; exits low-to-high
// - gate falling with nop enters power-down
// - gate falling during burst enters clock suspend; here only if that edge carries nop, deselect or burst stop
// - gate low freezes burst from next cycle
// - burst stop only during running burst
// - column access: read/write, column, auto precharge
// - byte mask high discards that write lane
// - activate moves named idle bank active
// - activation captures twelve-bit row address
// - controller waits activate-to-access delay
// - controller precharges before reactivating, spaced
// - controller spaces activations across banks
// - writes unmasked by default after activation
// - precharge closes only the named bank
// - controller honours minimum active time, except on precharge-all; no maximum
// - precharge-all closes every bank
module sdram_cmd_decode
   import sdram_cmd_pkg::*;
(
   input  wire logic                    i_mclk,
   input  wire logic                    i_rst,
   sdram_cmd_if.mem                     pins,
   input  wire logic [BURST_W-1:0]      i_burst_len,
   output logic      [BANKS-1:0]        o_bank_active,
   output logic      [BANKS*ADDR_W-1:0] o_open_rows,
   output logic      [1:0]              o_mode,
   output logic                         o_burst_busy,
   output logic      [COL_W-1:0]        o_col,
   output logic      [BANK_W-1:0]       o_burst_bank,
   output logic                         o_burst_write,
   output logic                         o_auto_pre,
   output logic                         o_wr_en,
   output logic      [DATA_W-1:0]       o_wr_data,
   output logic      [MASK_W-1:0]       o_wr_lanes,
   output logic                         o_refresh,
   output logic                         o_mode_load,
   output logic      [ADDR_W-1:0]       o_mode_opcode
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   localparam int PW = 5 + BANK_W + ADDR_W + MASK_W + DATA_W;
   logic [PW-1:0] meta_reg;
   logic [PW-1:0] samp_reg;
   logic          cke_prev_reg;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         meta_reg     <= '1;
         samp_reg     <= '1;
         cke_prev_reg <= 1'b1;
      end else begin
         meta_reg     <= {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n, pins.cke,
                          pins.bank_select, pins.addr, pins.byte_mask, pins.wdata};
         samp_reg     <= meta_reg;
         cke_prev_reg <= samp_reg[PW-5];
      end
   end

   wire               cs_n     = samp_reg[PW-1];
   wire [2:0]         strobes  = samp_reg[PW-2:PW-4];
   wire               cke      = samp_reg[PW-5];
   wire [BANK_W-1:0]  bank     = samp_reg[DATA_W+MASK_W+ADDR_W +: BANK_W];
   wire [ADDR_W-1:0]  addr     = samp_reg[DATA_W+MASK_W +: ADDR_W];
   wire [MASK_W-1:0]  mask     = samp_reg[DATA_W +: MASK_W];
   wire [DATA_W-1:0]  wdata    = samp_reg[DATA_W-1:0];

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   mode_type          mode_reg;
   mode_type          mode_next;
   logic [BANKS-1:0]  active_reg;
   logic [ADDR_W-1:0] row_reg [BANKS];
   logic              busy_reg;
   logic [BURST_W-1:0] left_reg;
   logic [BURST_W-1:0] len_reg;

   wire running   = (mode_reg == MODE_RUN);
   wire idle_nop  = cs_n || (strobes == CMD_NOP);
   wire live      = running && cke_prev_reg && !cs_n;
   wire all_idle  = (active_reg == '0);
   wire is_mode   = live && strobes == CMD_MODE && all_idle;
   wire is_refr   = live && strobes == CMD_REFR && all_idle;
   wire is_act    = live && strobes == CMD_ACT && !active_reg[bank];
   wire is_pre    = live && strobes == CMD_PRE;
   wire pre_all   = is_pre && addr[AP_BIT];
   wire is_col    = live && strobes[2] == 1'b1 && strobes[1] == 1'b0 && active_reg[bank];
   wire is_stop   = live && strobes == CMD_STOP && busy_reg;
   wire gate_fall = running && cke_prev_reg && !cke;
   wire gate_rise = !cke_prev_reg && cke;
   wire enter_pd  = gate_fall && idle_nop && !busy_reg;
   wire enter_sus = gate_fall && busy_reg && !(live && !idle_nop && strobes != CMD_STOP);
   wire enter_sr  = is_refr && !cke;
   wire frozen    = !cke_prev_reg;
   wire [BURST_W-1:0] eff_len = (i_burst_len == FULL_PAGE) ? BURST_W'(1 << COL_W) : i_burst_len;

   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         MODE_RUN: begin
            if (enter_sr)
               mode_next = MODE_SREF;
            else if (enter_sus)
               mode_next = MODE_SUSPEND;
            else if (enter_pd)
               mode_next = MODE_PDOWN;
         end
         MODE_PDOWN, MODE_SREF: begin
            if (gate_rise && idle_nop)
               mode_next = MODE_RUN;
         end
         MODE_SUSPEND: begin
            if (gate_rise)
               mode_next = MODE_RUN;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // mode, banks and rows
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         mode_reg   <= MODE_RUN;
         active_reg <= '0;
      end else begin
         mode_reg <= mode_next;
         if (is_act)
            active_reg[bank] <= 1'b1;
         else if (pre_all)
            active_reg <= '0;
         else if (is_pre)
            active_reg[bank] <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (is_act)
         row_reg[bank] <= addr;
   end

   // ---------------------------------------------------------------
   // burst tracking; the counter only models the burst's lifetime,
   // the column address is held as issued
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         busy_reg      <= 1'b0;
         left_reg      <= '0;
         len_reg       <= BURST_RESET;
         o_col         <= '0;
         o_burst_bank  <= '0;
         o_burst_write <= 1'b0;
         o_auto_pre    <= 1'b0;
      end else if (is_col) begin
         busy_reg      <= 1'b1;
         len_reg       <= i_burst_len;
         left_reg      <= eff_len - 9'h001;
         o_col         <= addr[COL_W-1:0];
         o_burst_bank  <= bank;
         o_burst_write <= !strobes[0];
         o_auto_pre    <= addr[AP_BIT] && (i_burst_len != FULL_PAGE);
      end else if (is_stop || (is_pre && (pre_all || bank == o_burst_bank))) begin
         busy_reg <= 1'b0;
      end else if (busy_reg && !frozen) begin
         if (left_reg == '0 && len_reg != FULL_PAGE)
            busy_reg <= 1'b0;
         else
            left_reg <= left_reg - 9'h001;
      end
   end

   // ---------------------------------------------------------------
   // write lanes and one-cycle strobes
   // ---------------------------------------------------------------
   // the issuing cycle is the first beat, so a burst of n spends only n-1 beats here
   wire beats_left = (left_reg != '0) || (len_reg == FULL_PAGE);
   wire wr_beat    = (is_col && !strobes[0]) ||
                     (busy_reg && o_burst_write && beats_left && !frozen && !is_col && !is_stop && running);

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_wr_en       <= 1'b0;
         o_wr_data     <= '0;
         o_wr_lanes    <= '0;
         o_refresh     <= 1'b0;
         o_mode_load   <= 1'b0;
         o_mode_opcode <= '0;
      end else begin
         o_wr_en     <= wr_beat;
         o_wr_data   <= wdata;
         o_wr_lanes  <= wr_beat ? ~mask : '0;
         o_refresh   <= is_refr && cke;
         o_mode_load <= is_mode;
         if (is_mode)
            o_mode_opcode <= addr;
      end
   end

   assign o_bank_active = active_reg;
   assign o_mode        = mode_reg;
   assign o_burst_busy  = busy_reg;
   for (genvar b = 0; b < BANKS; b++) begin : g_rows
      assign o_open_rows[b*ADDR_W +: ADDR_W] = row_reg[b];
   end
endmodule

// ---- rtl/sdram_cmd_ctrl.sv ----
/*
 holds the controller end: turns user requests into command pins and keeps
 the spacing the memory expects between activate, access and precharge.
 assumes the user holds a request until o_ack; pins are registered.
*/
module sdram_cmd_ctrl
   import sdram_cmd_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_rst,
   sdram_cmd_if.ctrl              pins,
   input  wire logic              i_req,
   input  wire logic [1:0]        i_req_kind,
   input  wire logic [BANK_W-1:0] i_bank,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [MASK_W-1:0] i_mask,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_cke,
   output logic                   o_ack,
   output logic [BANKS-1:0]       o_open
);
   // ---------------------------------------------------------------
   // spacing counters
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] rcd_reg [BANKS];
   logic [CNT_W-1:0] rc_reg  [BANKS];
   logic [CNT_W-1:0] ras_reg [BANKS];
   logic [CNT_W-1:0] rrd_reg;

   req_type kind;
   assign kind = req_type'(i_req_kind);

   wire act_ok  = !o_open[i_bank] && rc_reg[i_bank] == '0 && rrd_reg == '0;
   wire pre_ok  = (i_addr[AP_BIT] ? 1'b1 : ras_reg[i_bank] == '0);
   wire acc_ok  = o_open[i_bank] && rcd_reg[i_bank] == '0;
   // the gate already on the pins must be high, so a command never rides on a gate rise
   wire go      = i_req && !o_ack && i_cke && pins.cke &&
                  ((kind == REQ_ACT && act_ok) || (kind == REQ_PRE && pre_ok) ||
                   ((kind == REQ_READ || kind == REQ_WRITE) && acc_ok));

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rrd_reg <= '0;
         o_open  <= '0;
         for (int b = 0; b < BANKS; b++) begin
            rcd_reg[b] <= '0;
            rc_reg[b]  <= '0;
            ras_reg[b] <= '0;
         end
      end else begin
         if (rrd_reg != '0)
            rrd_reg <= rrd_reg - 4'h1;
         for (int b = 0; b < BANKS; b++) begin
            if (rcd_reg[b] != '0) rcd_reg[b] <= rcd_reg[b] - 4'h1;
            if (rc_reg[b] != '0)  rc_reg[b]  <= rc_reg[b] - 4'h1;
            if (ras_reg[b] != '0) ras_reg[b] <= ras_reg[b] - 4'h1;
         end
         if (go && kind == REQ_ACT) begin
            o_open[i_bank]  <= 1'b1;
            rrd_reg         <= cnt_of(BANK_TO_BANK_ACTIVATE_GAP_CYC);
            rcd_reg[i_bank] <= cnt_of(ACTIVATE_TO_ACCESS_DELAY_CYC);
            rc_reg[i_bank]  <= cnt_of(SAME_BANK_ACTIVATE_CYCLE_CYC);
            ras_reg[i_bank] <= cnt_of(ACTIVE_MIN_CYC);
         end else if (go && kind == REQ_PRE) begin
            if (i_addr[AP_BIT])
               o_open <= '0;
            else
               o_open[i_bank] <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // pin drive
   // ---------------------------------------------------------------
   wire [2:0] strobes = !go ? CMD_NOP :
                        kind == REQ_ACT  ? CMD_ACT  :
                        kind == REQ_PRE  ? CMD_PRE  :
                        kind == REQ_READ ? CMD_READ : CMD_WRITE;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pins.cs_n        <= 1'b1;
         {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_NOP;
         pins.cke         <= 1'b1;
         pins.bank_select <= '0;
         pins.addr        <= '0;
         pins.byte_mask   <= '0;
         pins.wdata       <= '0;
         o_ack            <= 1'b0;
      end else begin
         pins.cs_n        <= !go;
         {pins.ras_n, pins.cas_n, pins.we_n} <= strobes;
         pins.cke         <= i_cke;
         pins.bank_select <= i_bank;
         pins.addr        <= i_addr;
         pins.byte_mask   <= i_mask;
         pins.wdata       <= i_wdata;
         o_ack            <= go;
      end
   end
endmodule

// ---- sim/sdram_cmd_checker.sv ----
/*
 pin-level checks on the link between controller end and memory end.
 assumes one clock, and the link signals wired in by name beside the interface.
*/
module sdram_cmd_checker
   import sdram_cmd_pkg::*;
(
   input wire logic              i_mclk,
   input wire logic              i_rst,
   input wire logic              cs_n,
   input wire logic              ras_n,
   input wire logic              cas_n,
   input wire logic              we_n,
   input wire logic              cke,
   input wire logic [BANK_W-1:0] bank_select,
   input wire logic [ADDR_W-1:0] addr
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T_RCD = ACTIVATE_TO_ACCESS_DELAY_CYC;
   localparam int T_RC  = SAME_BANK_ACTIVATE_CYCLE_CYC;
   localparam int T_RAS = ACTIVE_MIN_CYC;
   wire logic [2:0]       cmd    = {ras_n, cas_n, we_n};
   wire logic             is_act = !cs_n && cmd == CMD_ACT;
   wire logic             is_acc = !cs_n && (cmd == CMD_READ || cmd == CMD_WRITE);
   wire logic             is_pre = !cs_n && cmd == CMD_PRE;
   logic [3:0]            age_reg [BANKS];
   logic [BANKS-1:0]      open_reg;
   // ---------------------------------------------------------------
   // cycles since each bank's activate; saturates so idle banks never look young
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         open_reg <= '0;
         for (int b = 0; b < BANKS; b++) begin
            age_reg[b] <= 4'hF;
         end
      end else begin
         for (int b = 0; b < BANKS; b++) begin
            if (is_act && bank_select == b) begin
               age_reg[b] <= 4'h1;
               open_reg[b] <= 1'b1;
            end else begin
               if (age_reg[b] != 4'hF) age_reg[b] <= age_reg[b] + 4'h1;
               if (is_pre && (addr[AP_BIT] || bank_select == b)) open_reg[b] <= 1'b0;
            end
         end
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   AST_RESET_IDLE: assert property ($fell(i_rst) |-> cs_n && cke)
      else $error("link not idle after reset");
   AST_CMD_NEEDS_GATE: assert property ((!cs_n && cmd != CMD_NOP) |-> $past(cke))
      else $error("command without clock gate high before");
   AST_GATE_LOW_NOP: assert property (!cke |-> cs_n || cmd == CMD_NOP)
      else $error("command issued with clock gate low");
   AST_ACCESS_DELAY: assert property (is_acc |-> age_reg[bank_select] >= T_RCD)
      else $error("access too soon after activate");
   AST_SAME_BANK_GAP: assert property (is_act |-> age_reg[bank_select] >= T_RC)
      else $error("same bank activated too soon");
   AST_ACT_CLOSED: assert property (is_act |-> !open_reg[bank_select])
      else $error("activate to an open bank");
   AST_BANK_GAP: assert property (is_act |=> !is_act)
      else $error("activates of two banks too close");
   AST_ACTIVE_MIN: assert property (is_pre && !addr[AP_BIT] && open_reg[bank_select]
      |-> age_reg[bank_select] >= T_RAS)
      else $error("precharge before minimum active time");
   cover property (is_act ##[1:8] is_acc);
   cover property (is_pre && addr[AP_BIT]);
   cover property ($fell(cke));
endmodule

// ---- sim/tb_top.sv ----
/*
 testbench: controller end and memory end joined by one link, plus a second
 memory end driven straight from the bench to reach modes the controller never asks for.
 assumes the package constants and one 125 MHz clock.
*/
module tb_top
   import sdram_cmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, rst, req, cke, ack, d_wr, d_bw, d_ap, r_busy, r_ref, r_ml;
   logic [1:0]        kind, bank, d_mode, r_mode, r_bb;
   logic [11:0]       addr, r, r_op;
   logic [3:0]        mask, mk, c_open, d_act, r_act, d_ln;
   logic [31:0]       wdata, d_wd;
   logic [47:0]       d_rows, r_rows;
   logic [7:0]        d_col, r_col;
   logic [35:0]       wexp;
   logic [35:0]       wq[$];
   int                fails, checks, nref, nml, m_act[4], m_row[4];
   sdram_cmd_if link ();
   sdram_cmd_if raw ();
   sdram_cmd_ctrl sdram_cmd_ctrl_inst (.i_mclk(clk), .i_rst(rst), .pins(link), .i_req(req), .i_req_kind(kind),
      .i_bank(bank), .i_addr(addr), .i_mask(mask), .i_wdata(wdata), .i_cke(cke), .o_ack(ack), .o_open(c_open));
   sdram_cmd_decode sdram_cmd_decode_inst (.i_mclk(clk), .i_rst(rst), .pins(link), .i_burst_len(9'h001),
      .o_bank_active(d_act), .o_open_rows(d_rows), .o_mode(d_mode), .o_burst_busy(), .o_col(d_col),
      .o_burst_bank(), .o_burst_write(d_bw), .o_auto_pre(d_ap), .o_wr_en(d_wr), .o_wr_data(d_wd),
      .o_wr_lanes(d_ln), .o_refresh(), .o_mode_load(), .o_mode_opcode());
   sdram_cmd_decode sdram_cmd_decode_inst_raw (.i_mclk(clk), .i_rst(rst), .pins(raw), .i_burst_len(FULL_PAGE),
      .o_bank_active(r_act), .o_open_rows(r_rows), .o_mode(r_mode), .o_burst_busy(r_busy), .o_col(r_col),
      .o_burst_bank(r_bb), .o_burst_write(), .o_auto_pre(), .o_wr_en(), .o_wr_data(), .o_wr_lanes(),
      .o_refresh(r_ref), .o_mode_load(r_ml), .o_mode_opcode(r_op));
   sdram_cmd_checker checker_inst (.i_mclk(clk), .i_rst(rst), .cs_n(link.cs_n), .ras_n(link.ras_n),
      .cas_n(link.cas_n), .we_n(link.we_n), .cke(link.cke), .bank_select(link.bank_select), .addr(link.addr));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // comparison, verdict and bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic ctrl_req(input logic [1:0] k, input logic [1:0] b, input logic [11:0] a,
                           input logic [3:0] m, input logic [31:0] d);
      int n;
      @(negedge clk);
      req = 1'b1;
      {kind, bank, addr, mask, wdata} = {k, b, a, m, d};
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (ack !== 1'b1 && n < 60);
      chk("ack", 1'b1, ack);
      if (ack !== 1'b1) end_of_test();
      @(negedge clk);
      req = 1'b0;
      addr = ~a;
      if (k == REQ_WRITE) wq.push_back({~m, d});
      if (k[1]) begin
         repeat (4) @(posedge clk);
         #1;
         chk("column", a[7:0], d_col);
         chk("burst_write", k == REQ_WRITE, d_bw);
         chk("auto_pre", a[AP_BIT], d_ap);
      end
   endtask
   // one command cycle on the bench-driven link, then nop; pulses counted over the settle time
   task automatic rawc(input logic c, input logic [2:0] k, input logic e, input logic [1:0] b,
                       input logic [11:0] a);
      @(negedge clk);
      {raw.cs_n, raw.ras_n, raw.cas_n, raw.we_n, raw.cke, raw.bank_select, raw.addr} = {c, k, e, b, a};
      @(negedge clk);
      {raw.cs_n, raw.ras_n, raw.cas_n, raw.we_n, raw.addr} = {1'b0, CMD_NOP, ~a};
      nref = 0;
      nml = 0;
      repeat (6) begin
         @(posedge clk);
         #1;
         nref += int'(r_ref === 1'b1);
         nml += int'(r_ml === 1'b1);
      end
   endtask
   task automatic cmp_banks;
      repeat (4) @(posedge clk);
      #1;
      for (int b = 0; b < BANKS; b++) begin
         chk("bank_active", m_act[b], d_act[b]);
         chk("ctrl_open", m_act[b], c_open[b]);
         if (m_act[b] != 0) chk("open_row", m_row[b], d_rows[b*ADDR_W+:ADDR_W]);
      end
   endtask
   // write beats are looked at mid-cycle, away from the edge that launches them
   always @(negedge clk) begin
      if (d_wr === 1'b1) begin
         wexp = (wq.size() > 0) ? wq.pop_front() : ~36'h0;
         chk("write_data", wexp[31:0], d_wd);
         chk("write_lanes", wexp[35:32], d_ln);
      end
   end
   initial begin
      {rst, req, cke} = 3'h5;
      {kind, bank, addr, mask, wdata} = '0;
      {raw.cs_n, raw.ras_n, raw.cas_n, raw.we_n, raw.cke, raw.bank_select, raw.addr} = 19'h7C000;
      {raw.byte_mask, raw.wdata} = '0;
      {fails, checks} = '0;
      m_act = '{default: 0};
      m_row = '{default: 0};
      void'($urandom(26757));
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      cmp_banks();
      for (int b = 0; b < BANKS; b++) begin
         r = 12'($urandom);
         ctrl_req(REQ_ACT, 2'(b), r, 4'h0, 32'h0);
         m_act[b] = 1;
         m_row[b] = int'(r);
      end
      cmp_banks();
      for (int i = 0; i < 6; i++) begin
         mk = (i < 4) ? 4'h1 << i : 4'($urandom);
         ctrl_req(REQ_WRITE, 2'(i), 12'($urandom) & 12'hBFF, mk, $urandom);
      end
      ctrl_req(REQ_READ, 2'h0, 12'($urandom) & 12'hBFF, 4'h0, 32'h0);
      ctrl_req(REQ_PRE, 2'h1, 12'h000, 4'h0, 32'h0);
      m_act[1] = 0;
      cmp_banks();
      ctrl_req(REQ_READ, 2'h3, 12'($urandom) | 12'h400, 4'h0, 32'h0);
      ctrl_req(REQ_PRE, 2'h2, 12'h400, 4'h0, 32'h0);
      m_act = '{default: 0};
      cmp_banks();
      chk("writes_left", 0, wq.size());
      @(negedge clk);
      cke = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("mode", MODE_PDOWN, d_mode);
      @(negedge clk);
      cke = 1'b1;
      r = 12'($urandom);
      ctrl_req(REQ_ACT, 2'h0, r, 4'h0, 32'h0);
      m_act[0] = 1;
      m_row[0] = int'(r);
      cmp_banks();
      rawc(1'b1, CMD_ACT, 1'b1, 2'h2, 12'h123);
      chk("mode", MODE_RUN, d_mode);
      chk("deselect", 4'h0, r_act);
      r = 12'($urandom);
      rawc(1'b0, CMD_MODE, 1'b1, 2'h0, r);
      chk("mode_load", 1, nml);
      chk("opcode", r, r_op);
      rawc(1'b0, CMD_REFR, 1'b1, 2'h0, 12'h000);
      chk("refresh", 1, nref);
      rawc(1'b0, CMD_ACT, 1'b1, 2'h2, r);
      rawc(1'b0, CMD_ACT, 1'b1, 2'h2, ~r);
      chk("bank_active", 4'h4, r_act);
      chk("open_row", r, r_rows[2*ADDR_W+:ADDR_W]);
      rawc(1'b0, CMD_REFR, 1'b1, 2'h0, 12'h000);
      chk("refresh", 0, nref);
      rawc(1'b0, CMD_MODE, 1'b1, 2'h0, ~r);
      chk("mode_load", 0, nml);
      rawc(1'b0, CMD_READ, 1'b1, 2'h2, 12'h011);
      chk("burst_busy", 1'b1, r_busy);
      chk("burst_bank", 2'h2, r_bb);
      chk("column", 8'h11, r_col);
      rawc(1'b0, CMD_NOP, 1'b0, 2'h0, 12'h000);
      chk("mode", MODE_SUSPEND, r_mode);
      chk("burst_busy", 1'b1, r_busy);
      rawc(1'b0, CMD_NOP, 1'b1, 2'h0, 12'h000);
      chk("mode", MODE_RUN, r_mode);
      rawc(1'b0, CMD_STOP, 1'b1, 2'h0, 12'h000);
      chk("burst_busy", 1'b0, r_busy);
      rawc(1'b0, CMD_PRE, 1'b1, 2'h0, 12'h400);
      chk("bank_active", 4'h0, r_act);
      rawc(1'b0, CMD_NOP, 1'b0, 2'h0, 12'h000);
      chk("mode", MODE_PDOWN, r_mode);
      rawc(1'b1, CMD_NOP, 1'b1, 2'h0, 12'h000);
      chk("mode", MODE_RUN, r_mode);
      rawc(1'b0, CMD_REFR, 1'b0, 2'h0, 12'h000);
      chk("mode", MODE_SREF, r_mode);
      rawc(1'b0, CMD_NOP, 1'b1, 2'h0, 12'h000);
      chk("mode", MODE_RUN, r_mode);
      end_of_test();
   end
endmodule
